/* File: design/umra_pkg.sv */
package umra_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] UMRA_OFS_ID      = 7'h00;
    localparam logic [6:0] UMRA_OFS_VERSION = 7'h01;
    localparam logic [6:0] UMRA_OFS_SCRATCH = 7'h02;
    localparam logic [6:0] UMRA_OFS_TEMP    = 7'h03;
    localparam logic [6:0] UMRA_OFS_FAN_LO  = 7'h04;
    localparam logic [6:0] UMRA_OFS_FAN_HI  = 7'h05;
    localparam logic [6:0] UMRA_OFS_FAULT   = 7'h06;
    localparam logic [6:0] UMRA_OFS_CTRL    = 7'h0f;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         UMRA_CTRL_I2C_OFF_BIT = 0;
    localparam int         UMRA_CTRL_CLEAR_BIT   = 1;
    localparam int         UMRA_FAULT_FAN_BIT    = 0;
    localparam int         UMRA_HDR_RD_BIT       = 0;
    localparam logic [7:0] UMRA_SCRATCH_RST      = 8'h00;
    localparam logic [7:0] UMRA_CTRL_RST         = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int UMRA_CLK_HZ      = 40000000;
    localparam int UMRA_BAUD        = 115200;
    localparam int UMRA_BIT_CYC     = UMRA_CLK_HZ / UMRA_BAUD;
    localparam int UMRA_LONG_MS     = 1000;
    localparam int UMRA_LONG_CYC    = (UMRA_CLK_HZ / 1000) * UMRA_LONG_MS;
    localparam int UMRA_UART_FRAME  = 11;   // Start, 8 data, parity, stop

    // ------------------------------------------------------------------
    // Frame parser states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        UMRA_ST_ADDR_HI = 3'b000,
        UMRA_ST_ADDR_LO = 3'b001,
        UMRA_ST_CNT_HI  = 3'b010,
        UMRA_ST_CNT_LO  = 3'b011,
        UMRA_ST_WR_HI   = 3'b100,
        UMRA_ST_WR_LO   = 3'b101,
        UMRA_ST_RD      = 3'b110
    } umra_state_t;

endpackage : umra_pkg

/* File: design/umra_top.sv */
`timescale 1ns/1ps
`default_nettype none
module umra_top
    import umra_pkg::*;
#(
    parameter int         BIT_CYC   = UMRA_BIT_CYC,
    parameter int         LONG_CYC  = UMRA_LONG_CYC,
    parameter logic [7:0] ID_VALUE  = 8'h5a,  // Arbitrary identity value
    parameter logic [3:0] FW_MAJOR  = 4'h1,
    parameter logic [3:0] FW_MINOR  = 4'h0
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Serial link to host
    input  wire logic        i_rxd,
    output logic             o_txd,
    // Measurements from the management logic
    input  wire logic [7:0]  i_core_temp,
    input  wire logic [15:0] i_fan_rpm,
    input  wire logic        i_fan_out_of_range,
    // Control outputs
    output logic             o_regulator_i2c_off,
    output logic             o_status_led,
    output logic             o_frame_error
);

    // ------------------------------------------------------------------
    // Receive line synchroniser
    // ------------------------------------------------------------------
    logic rxd_meta_reg;
    logic rxd_sync_reg;

    // Two stages before the receiver looks at the pin
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= i_rxd;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // UART receiver, 8E1
    // ------------------------------------------------------------------
    logic [15:0] rx_cyc_reg;
    logic [3:0]  rx_bits_reg;
    logic [9:0]  rx_shift_reg;
    logic        rx_busy_reg;
    logic        rx_valid_reg;
    logic [7:0]  rx_data_reg;
    logic        rx_perr_reg;

    // Samples mid-bit; start bit rechecked at half period to reject glitches
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_cyc_reg   <= 16'h0000;
            rx_bits_reg  <= 4'h0;
            rx_shift_reg <= 10'h000;
            rx_busy_reg  <= 1'b0;
            rx_valid_reg <= 1'b0;
            rx_data_reg  <= 8'h00;
            rx_perr_reg  <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            rx_perr_reg  <= 1'b0;
            if (!rx_busy_reg) begin
                if (!rxd_sync_reg) begin
                    rx_busy_reg <= 1'b1;
                    rx_cyc_reg  <= 16'(BIT_CYC / 2);
                    rx_bits_reg <= 4'h0;
                end
            end else if (rx_cyc_reg == 16'(BIT_CYC - 1)) begin
                rx_cyc_reg <= 16'h0000;
                if (rx_bits_reg == 4'h0 && rxd_sync_reg) begin
                    rx_busy_reg <= 1'b0;      // False start
                end else if (rx_bits_reg == 4'ha) begin
                    rx_busy_reg <= 1'b0;
                    // Even parity and stop bit checked
                    if (rxd_sync_reg && !(^rx_shift_reg[9:1])) begin
                        rx_valid_reg <= 1'b1;
                        rx_data_reg  <= rx_shift_reg[8:1];
                    end else begin
                        rx_perr_reg <= 1'b1;
                    end
                end else begin
                    rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[9:1]};
                    rx_bits_reg  <= rx_bits_reg + 4'h1;
                end
            end else begin
                rx_cyc_reg <= rx_cyc_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // ASCII hex decode and encode
    // ------------------------------------------------------------------
    logic       chr_is_hex;
    logic [3:0] chr_nibble;

    // Accepts 0-9, A-F and a-f
    always_comb begin
        chr_is_hex = 1'b1;
        chr_nibble = 4'h0;
        if (rx_data_reg >= 8'h30 && rx_data_reg <= 8'h39) begin
            chr_nibble = 4'(rx_data_reg - 8'h30);
        end else if (rx_data_reg >= 8'h41 && rx_data_reg <= 8'h46) begin
            chr_nibble = 4'(rx_data_reg - 8'h37);
        end else if (rx_data_reg >= 8'h61 && rx_data_reg <= 8'h66) begin
            chr_nibble = 4'(rx_data_reg - 8'h57);
        end else begin
            chr_is_hex = 1'b0;
        end
    end

    function automatic logic [7:0] umra_hex_chr(input logic [3:0] n);
        return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : umra_hex_chr

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] scratch_reg;
    logic [7:0] ctrl_reg;
    logic       fault_latch_reg;
    logic [6:0] ptr_reg;
    logic [7:0] rd_byte;
    logic       wr_stb;
    logic [7:0] wr_byte;

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (ptr_reg)
            UMRA_OFS_ID:      rd_byte = ID_VALUE;
            UMRA_OFS_VERSION: rd_byte = {FW_MAJOR, FW_MINOR};
            UMRA_OFS_SCRATCH: rd_byte = scratch_reg;
            UMRA_OFS_TEMP:    rd_byte = i_core_temp;
            UMRA_OFS_FAN_LO:  rd_byte = i_fan_rpm[7:0];
            UMRA_OFS_FAN_HI:  rd_byte = i_fan_rpm[15:8];
            UMRA_OFS_FAULT:   rd_byte = {7'h00, fault_latch_reg};
            UMRA_OFS_CTRL:    rd_byte = ctrl_reg;
            default:          rd_byte = 8'h00;
        endcase
    end

    // Scratch holds the last written value
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            scratch_reg <= UMRA_SCRATCH_RST;
        end else if (wr_stb && ptr_reg == UMRA_OFS_SCRATCH) begin
            scratch_reg <= wr_byte;
        end
    end

    // Control: bit 0 gates regulator I2C, bit 1 is a self-clearing clear
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_reg <= UMRA_CTRL_RST;
        end else if (wr_stb && ptr_reg == UMRA_OFS_CTRL) begin
            ctrl_reg <= {6'h00, wr_byte[UMRA_CTRL_CLEAR_BIT],
                         wr_byte[UMRA_CTRL_I2C_OFF_BIT]};
        end else if (ctrl_reg[UMRA_CTRL_CLEAR_BIT]) begin
            ctrl_reg[UMRA_CTRL_CLEAR_BIT] <= 1'b0;
        end
    end

    // Fault latch: an out-of-range sample wins over a clear in same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            fault_latch_reg <= 1'b0;
        end else if (i_fan_out_of_range) begin
            fault_latch_reg <= 1'b1;
        end else if (ctrl_reg[UMRA_CTRL_CLEAR_BIT]) begin
            fault_latch_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_regulator_i2c_off <= 1'b0;
        end else begin
            o_regulator_i2c_off <= ctrl_reg[UMRA_CTRL_I2C_OFF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Frame parser
    // ------------------------------------------------------------------
    umra_state_t state_reg;
    logic [3:0]  hi_nib_reg;
    logic [8:0]  count_reg;    // 0 count means 256 is not reachable; 1..255
    logic        tx_hi_reg;
    logic        tx_valid;
    logic [7:0]  tx_chr;
    logic        tx_ready;
    logic        chr_ok;
    logic [7:0]  rx_byte;

    assign chr_ok  = rx_valid_reg && chr_is_hex;
    assign rx_byte = {hi_nib_reg, chr_nibble};
    assign wr_stb  = (state_reg == UMRA_ST_WR_LO) && chr_ok;
    assign wr_byte = rx_byte;
    assign tx_valid = (state_reg == UMRA_ST_RD);
    // High nibble first on the line
    assign tx_chr  = tx_hi_reg ? umra_hex_chr(rd_byte[7:4])
                               : umra_hex_chr(rd_byte[3:0]);

    // Address, count, then data; non-hex characters are dropped
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg  <= UMRA_ST_ADDR_HI;
            hi_nib_reg <= 4'h0;
            ptr_reg    <= 7'h00;
            count_reg  <= 9'h000;
            tx_hi_reg  <= 1'b1;
        end else begin
            case (state_reg)
                UMRA_ST_ADDR_HI, UMRA_ST_CNT_HI, UMRA_ST_WR_HI: begin
                    if (chr_ok) begin
                        hi_nib_reg <= chr_nibble;
                        state_reg  <= umra_state_t'(state_reg + 3'h1);
                    end
                end
                UMRA_ST_ADDR_LO: begin
                    if (chr_ok) begin
                        ptr_reg   <= rx_byte[7:1];
                        tx_hi_reg <= rx_byte[UMRA_HDR_RD_BIT];
                        state_reg <= UMRA_ST_CNT_HI;
                    end
                end
                UMRA_ST_CNT_LO: begin
                    if (chr_ok) begin
                        count_reg <= {1'b0, rx_byte};
                        if (rx_byte == 8'h00) begin
                            state_reg <= UMRA_ST_ADDR_HI;
                        end else if (tx_hi_reg) begin
                            state_reg <= UMRA_ST_RD;
                        end else begin
                            state_reg <= UMRA_ST_WR_HI;
                        end
                        tx_hi_reg <= 1'b1;
                    end
                end
                UMRA_ST_WR_LO: begin
                    // Waits for exactly count bytes
                    if (chr_ok) begin
                        ptr_reg   <= ptr_reg + 7'h01;
                        count_reg <= count_reg - 9'h001;
                        state_reg <= (count_reg == 9'h001)
                                     ? UMRA_ST_ADDR_HI : UMRA_ST_WR_HI;
                    end
                end
                UMRA_ST_RD: begin
                    if (tx_ready) begin
                        tx_hi_reg <= !tx_hi_reg;
                        if (!tx_hi_reg) begin
                            ptr_reg   <= ptr_reg + 7'h01;
                            count_reg <= count_reg - 9'h001;
                            if (count_reg == 9'h001) begin
                                state_reg <= UMRA_ST_ADDR_HI;
                            end
                        end
                    end
                end
                default: state_reg <= UMRA_ST_ADDR_HI;
            endcase
        end
    end

    // Parity or framing fault on any received character, one-cycle pulse
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_frame_error <= 1'b0;
        end else begin
            o_frame_error <= rx_perr_reg;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    umra_uart_tx #(
        .BIT_CYC (BIT_CYC)
    ) u_tx (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_valid (tx_valid),
        .i_data  (tx_chr),
        .o_ready (tx_ready),
        .o_txd   (o_txd)
    );

    // ------------------------------------------------------------------
    // Status LED: fan fault blinks long on, long off
    // ------------------------------------------------------------------
    logic [31:0] led_cyc_reg;

    // Only one fault source here, so it is always the highest priority
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            led_cyc_reg  <= 32'h0000_0000;
            o_status_led <= 1'b0;
        end else if (!fault_latch_reg) begin
            // Primed to the last count so a new fault lights at once
            led_cyc_reg  <= 32'(LONG_CYC - 1);
            o_status_led <= 1'b0;
        end else if (led_cyc_reg == 32'(LONG_CYC - 1)) begin
            // Equal halves: LONG_CYC lit, then LONG_CYC dark
            led_cyc_reg  <= 32'h0000_0000;
            o_status_led <= !o_status_led;
        end else begin
            led_cyc_reg <= led_cyc_reg + 32'h0000_0001;
        end
    end

endmodule : umra_top
`default_nettype wire

/* File: design/umra_uart_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module umra_uart_tx
    import umra_pkg::*;
#(
    parameter int BIT_CYC = UMRA_BIT_CYC
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // Character to send
    input  wire logic       i_valid,
    input  wire logic [7:0] i_data,
    output logic            o_ready,
    // Serial line
    output logic            o_txd
);

    logic [10:0] shift_reg;
    logic [3:0]  bits_reg;
    logic [15:0] cyc_reg;

    // ------------------------------------------------------------------
    // Shifter: start bit, data LSB first, even parity, stop bit
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            shift_reg <= 11'h7ff;
            bits_reg  <= 4'h0;
            cyc_reg   <= 16'h0000;
            o_txd     <= 1'b1;
            o_ready   <= 1'b1;
        end else if (bits_reg == 4'h0) begin
            o_txd <= 1'b1;
            if (i_valid && o_ready) begin
                // Parity kept even over the data bits
                shift_reg <= {1'b1, ^i_data, i_data, 1'b0};
                bits_reg  <= 4'(UMRA_UART_FRAME);
                cyc_reg   <= 16'h0000;
                o_ready   <= 1'b0;
            end else begin
                o_ready <= 1'b1;
            end
        end else begin
            o_txd <= shift_reg[0];
            if (cyc_reg == 16'(BIT_CYC - 1)) begin
                cyc_reg   <= 16'h0000;
                shift_reg <= {1'b1, shift_reg[10:1]};
                bits_reg  <= bits_reg - 4'h1;
            end else begin
                cyc_reg <= cyc_reg + 16'h0001;
            end
        end
    end

endmodule : umra_uart_tx
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int         BIT_CYC  = 8;
    localparam int         LONG_CYC = 20;
    localparam int         WR_GAP   = 200;   // Write pause, scaled down
    localparam logic [7:0] ID_VAL   = 8'h3c; // Arbitrary identity value
    logic        clk = 1'b0;
    logic        rst, rxd, txd, fan_oor, i2c_off, status_led, frame_err;
    logic [7:0]  core_temp;
    logic [15:0] fan_rpm;
    int          failures = 0;
    int          n_checks = 0;
    int          ferr_cnt = 0;
    int          led_on;
    logic [7:0]  rd_buf [4];
    logic [6:0]  rsv_ofs [4] = '{7'h07, 7'h0e, 7'h10, 7'h70};

    always #12.5 clk = ~clk;

    umra_top #(.BIT_CYC(BIT_CYC), .LONG_CYC(LONG_CYC), .ID_VALUE(ID_VAL),
        .FW_MAJOR(4'h2), .FW_MINOR(4'h7)) u_umra_top (.i_clk(clk),
        .i_reset(rst), .i_rxd(rxd), .o_txd(txd), .i_core_temp(core_temp),
        .i_fan_rpm(fan_rpm), .i_fan_out_of_range(fan_oor),
        .o_regulator_i2c_off(i2c_off), .o_status_led(status_led),
        .o_frame_error(frame_err));
    umra_host_model #(.BIT_CYC(BIT_CYC)) u_umra_host_model (.i_clk(clk),
        .o_rxd(rxd), .i_txd(txd));

    // Frame error pulses are counted, one per character with a parity or stop fault
    always @(posedge clk) if (frame_err === 1'b1) ferr_cnt++;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic send_hdr(input logic [6:0] ofs, input logic rd,
                            input logic [7:0] n);
        u_umra_host_model.send_byte({ofs, rd});
        u_umra_host_model.send_byte(n);
    endtask : send_hdr

    // Every write is followed by the host's pause before the next frame
    task automatic reg_write(input logic [6:0] ofs, input logic [7:0] val);
        send_hdr(ofs, 1'b0, 8'h01);
        u_umra_host_model.send_byte(val);
        repeat (WR_GAP) @(posedge clk);
    endtask : reg_write

    task automatic reg_read(input logic [6:0] ofs, input int n);
        send_hdr(ofs, 1'b1, 8'(n));
        for (int i = 0; i < n; i++) u_umra_host_model.get_byte(rd_buf[i]);
    endtask : reg_read

    task automatic finish_test;
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog sized well past the whole sequence
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        rst = 1'b1;
        core_temp = 8'h47;
        fan_rpm = 16'h0c15;
        fan_oor = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        // Identity, version and scratch default in one burst
        reg_read(7'h00, 3);
        check(rd_buf[0], ID_VAL);
        check(rd_buf[1], 8'h27);
        check(rd_buf[2], 8'h00);
        // Two-byte write from the version: its byte is ignored
        send_hdr(7'h01, 1'b0, 8'h02);
        u_umra_host_model.send_byte(8'h99);
        u_umra_host_model.send_byte(8'ha5);
        repeat (WR_GAP) @(posedge clk);
        reg_read(7'h01, 2);
        check(rd_buf[0], 8'h27);
        check(rd_buf[1], 8'ha5);
        // Temperature, fan speed low then high, fault status
        reg_read(7'h03, 4);
        check(rd_buf[0], 8'h47);
        check(rd_buf[1], 8'h15);
        check(rd_buf[2], 8'h0c);
        check(rd_buf[3], 8'h00);
        // Reserved places swallow writes and read zero
        for (int i = 0; i < 4; i++) begin
            reg_write(rsv_ofs[i], 8'hff);
            reg_read(rsv_ofs[i], 1);
            check(rd_buf[0], 8'h00);
        end
        // Regulator bus gate on, then off again
        reg_write(7'h0f, 8'h01);
        reg_read(7'h0f, 1);
        check(rd_buf[0], 8'h01);
        check(i2c_off, 1'b1);
        reg_write(7'h0f, 8'h00);
        check(i2c_off, 1'b0);
        // Short out-of-range pulse latches the fault and lights the lamp
        #1 fan_oor = 1'b1;
        repeat (3) @(posedge clk);
        #1 fan_oor = 1'b0;
        for (int t = 0; t < 2 * LONG_CYC + 8 && status_led !== 1'b1; t++)
            @(posedge clk);
        check(status_led, 1'b1);
        // Lit half ends, then the dark half must last a full long count
        for (int t = 0; t < 4 * LONG_CYC && status_led !== 1'b0; t++)
            @(posedge clk);
        led_on = 0;
        for (int t = 0; t < 4 * LONG_CYC && status_led !== 1'b1; t++) begin
            @(posedge clk);
            led_on++;
        end
        check(16'(led_on), 16'(LONG_CYC));
        reg_read(7'h06, 1);
        check(rd_buf[0], 8'h01);
        // Clear all faults: lamp dark, fault and clear bit read zero
        reg_write(7'h0f, 8'h02);
        led_on = 0;
        repeat (3 * LONG_CYC) begin
            @(posedge clk);
            if (status_led !== 1'b0) led_on++;
        end
        check(16'(led_on), 16'h0000);
        reg_read(7'h06, 1);
        check(rd_buf[0], 8'h00);
        reg_read(7'h0f, 1);
        check(rd_buf[0], 8'h00);
        // Bad parity character is dropped and flagged
        u_umra_host_model.send_char(8'h31, 1'b1);
        repeat (BIT_CYC) @(posedge clk);
        check(16'(ferr_cnt), 16'h0001);
        reg_read(7'h02, 1);
        check(rd_buf[0], 8'ha5);
        check(16'(u_umra_host_model.rx_bad), 16'h0000);
        finish_test();
    end
endmodule : testbench
`default_nettype wire

/* File: verif/umra_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module umra_assertions
    import umra_pkg::*;
#(
    parameter int BIT_CYC  = UMRA_BIT_CYC,
    parameter int LONG_CYC = UMRA_LONG_CYC
) (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset,
    // Serial link
    input wire logic        i_rxd,
    input wire logic        o_txd,
    // Measurements
    input wire logic [7:0]  i_core_temp,
    input wire logic [15:0] i_fan_rpm,
    input wire logic        i_fan_out_of_range,
    // Outputs under watch
    input wire logic        o_regulator_i2c_off,
    input wire logic        o_status_led,
    input wire logic        o_frame_error
);
    localparam int LED_WIN = 2 * LONG_CYC + 4;
    localparam int LOW_MAX = 10 * BIT_CYC + 2;
    logic [31:0] led_on_cnt;
    logic [31:0] txd_low_cnt;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Run lengths of the lit lamp and of the low line
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            led_on_cnt  <= '0;
            txd_low_cnt <= '0;
        end else begin
            led_on_cnt  <= o_status_led ? led_on_cnt + 1 : '0;
            txd_low_cnt <= o_txd ? '0 : txd_low_cnt + 1;
        end
    end

    // Bit cells; the repetition counts assume a bench BIT_CYC of 8
    sequence s_cell_low;
        (!o_txd)[*8];
    endsequence
    sequence s_cell_high;
        o_txd[*8];
    endsequence

    txd_low_hold_a: assert property ($fell(o_txd) |-> s_cell_low)
        else $error("serial low cell too short");
    txd_high_hold_a: assert property ($rose(o_txd) |-> s_cell_high)
        else $error("serial high cell too short");
    txd_frame_max_a: assert property (!o_txd |-> txd_low_cnt < LOW_MAX)
        else $error("serial line low beyond one frame");
    led_on_fault_a: assert property (
        i_fan_out_of_range |-> ##[0:LED_WIN] o_status_led)
        else $error("lamp did not light on fan fault");
    led_on_len_a: assert property (
        o_status_led |-> led_on_cnt < LONG_CYC)
        else $error("lamp lit longer than a long blink");
    ferr_pulse_a: assert property ($rose(o_frame_error) |=> !o_frame_error)
        else $error("frame error longer than one cycle");
    reset_idle_a: assert property (disable iff (1'b0)
        i_reset |-> o_txd && !o_status_led && !o_regulator_i2c_off)
        else $error("outputs not at defaults in reset");
    release_idle_a: assert property (disable iff (1'b0)
        $fell(i_reset) |-> o_txd[*4])
        else $error("serial line not idle after reset");
endmodule : umra_assertions

bind umra_top umra_assertions #(.BIT_CYC(BIT_CYC), .LONG_CYC(LONG_CYC))
    u_umra_assertions (.i_clk(i_clk), .i_reset(i_reset), .i_rxd(i_rxd),
    .o_txd(o_txd), .i_core_temp(i_core_temp), .i_fan_rpm(i_fan_rpm),
    .i_fan_out_of_range(i_fan_out_of_range),
    .o_regulator_i2c_off(o_regulator_i2c_off),
    .o_status_led(o_status_led), .o_frame_error(o_frame_error));
`default_nettype wire

/* File: verif/umra_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module umra_host_model #(
    parameter int BIT_CYC = 8
) (
    // Clock
    input  wire logic i_clk,
    // Serial link seen from the host
    output logic      o_rxd,
    input  wire logic i_txd
);
    logic [7:0] rx_q[$];
    int         rx_bad = 0;

    // Host sends upper-case hex digits
    function automatic logic [7:0] to_hex(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : to_hex

    function automatic logic [3:0] from_hex(input logic [7:0] c);
        if (c < 8'h3a) return 4'(c - 8'h30);
        if (c < 8'h47) return 4'(c - 8'h37);
        return 4'(c - 8'h57);
    endfunction : from_hex

    initial o_rxd = 1'b1;

    // One 8E1 character; bad flips the parity on purpose
    task automatic send_char(input logic [7:0] c, input logic bad);
        logic [10:0] frame;
        frame = {1'b1, ^c ^ bad, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge i_clk);
            #1 o_rxd = frame[i];
            repeat (BIT_CYC - 1) @(posedge i_clk);
        end
    endtask : send_char

    // High nibble first, so 0x0c goes out as "0C"
    task automatic send_byte(input logic [7:0] b);
        send_char(to_hex(b[7:4]), 1'b0);
        send_char(to_hex(b[3:0]), 1'b0);
    endtask : send_byte

    // Bounded wait: a silent device counts as a bad reception
    task automatic get_byte(output logic [7:0] b);
        for (int k = 0; k < 2; k++) begin
            for (int t = 0; t < 40 * BIT_CYC && rx_q.size() == 0; t++)
                @(posedge i_clk);
            if (rx_q.size() == 0) begin
                rx_bad++;
                b = 8'hee;
            end else begin
                b = {b[3:0], from_hex(rx_q.pop_front())};
            end
        end
    endtask : get_byte

    // Receiver samples mid-cell and checks parity and stop
    always begin
        logic [9:0] bits;
        @(negedge i_txd);
        repeat (BIT_CYC / 2) @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CYC) @(posedge i_clk);
            bits[i] = i_txd;
        end
        if (^bits[8:0] !== 1'b0 || bits[9] !== 1'b1) rx_bad++;
        rx_q.push_back(bits[7:0]);
    end
endmodule : umra_host_model
`default_nettype wire
